/* rtl/fiv_pkg.sv */
package fiv_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSRC  = 28;
  localparam int NTRIG = 6;
  localparam int NLVL  = 8;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_NEST_CTRL = 32'hFFFF0030;
  localparam logic [31:0] OFS_TRIG_SEL  = 32'hFFFF0034;
  localparam logic [31:0] OFS_EDGE_CLR  = 32'hFFFF0038;
  localparam logic [31:0] OFS_FAST_VEC  = 32'hFFFF011C;
  localparam logic [31:0] OFS_FAST_STAT = 32'hFFFF013C;
  localparam logic [31:0] OFS_EVT_STAT  = 32'hFFFF0140;
  localparam logic [31:0] OFS_EVT_MASK  = 32'hFFFF0144;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_NEST_CTRL = 2'h0;
  localparam logic [11:0] RST_TRIG_SEL  = 12'h000;
  localparam logic [7:0]  RST_FAST_STAT = 8'h00;
  localparam logic [2:0]  RST_EVT       = 3'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NEST_NORM_BIT = 0;
  localparam int NEST_FAST_BIT = 1;
  localparam int VEC_SRC_LSB   = 2;
  localparam int VEC_BASE_LSB  = 7;
  localparam int VEC_BASE_W    = 16;
  localparam int EVT_FAST_BIT  = 0;
  localparam int EVT_NORM_BIT  = 1;
  localparam int EVT_PUSH_BIT  = 2;
  // Input order: pin0, pin1, pin2, pin3, logic0, logic1
  localparam int TRIG_LSB [NTRIG] = '{0, 2, 6, 8, 4, 10};
  localparam int CLR_BIT  [NTRIG] = '{13, 16, 18, 19, 17, 20};
  localparam int SRC_IDX  [NTRIG] = '{13, 16, 18, 19, 17, 20};

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TRIG_HIGH   = 2'h0;
  localparam logic [1:0] TRIG_LOW    = 2'h1;
  localparam logic [1:0] TRIG_RISE   = 2'h2;
  localparam logic [1:0] TRIG_FALL   = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Index of the lowest set bit, NLVL when none is set
  function automatic logic [3:0] lowest_set8(input logic [7:0] v);
    logic [3:0] r;
    r = 4'(NLVL);
    for (int i = NLVL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

endpackage

/* rtl/fiv_trig_cond.sv */
`timescale 1ns/1ps
`default_nettype none

module fiv_trig_cond (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Source and control
  input  wire logic       src_async,
  input  wire logic [1:0] mode,
  input  wire logic       edge_clr,
  // Conditioned request
  output var  logic       pending
);
  import fiv_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic latch;
    logic pend;
  } fiv_cond_state_t;

  fiv_cond_state_t s_r;
  fiv_cond_state_t s_nxt;
  logic            hit;

  // Sync, detect the chosen edge, hold it until cleared
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = src_async;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    hit = (mode == TRIG_RISE) ? (s_r.sync2 & ~s_r.prev)
                              : (s_r.sync2 == 1'b0 && s_r.prev);
    if (mode == TRIG_HIGH || mode == TRIG_LOW) begin
      s_nxt.latch = 1'b0;
      s_nxt.pend  = s_r.sync2 ^ mode[0];
    end else begin
      // New edge wins over a clear in the same cycle
      s_nxt.latch = hit | (s_r.latch & ~edge_clr);
      s_nxt.pend  = s_nxt.latch;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pending = s_r.pend;

endmodule

`default_nettype wire

/* rtl/fiv_prio_pick.sv */
`timescale 1ns/1ps
`default_nettype none

module fiv_prio_pick (
  // Requests
  input  wire logic [27:0] req,
  input  wire logic [83:0] prio,
  // Nesting
  input  wire logic        nest_en,
  input  wire logic [7:0]  stat,
  // Winner
  output logic             any,
  output logic [4:0]       src,
  output logic [2:0]       lvl
);
  import fiv_pkg::*;

  logic [3:0] thr;
  logic [2:0] p;

  // With nesting on the lowest priority value wins; ties, and every pick with nesting off, go to the lower source number
  always_comb begin
    thr = lowest_set8(stat);
    any = 1'b0;
    src = 5'h00;
    lvl = 3'h0;
    p   = 3'h0;
    for (int i = 0; i < NSRC; i++) begin
      p = prio[3*i +: 3];
      // Levels at or below the serviced one stay blocked
      if (req[i] && (!nest_en || {1'b0, p} < thr)) begin
        if (!any || (nest_en && p < lvl)) begin
          any = 1'b1;
          src = 5'(i);
          lvl = p;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/fiv_fast_irq_ctrl.sv */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - The vector word reads zero in 31:23, the base in 22:7, the winning source in 6:2, zero in 1:0.
// - A vector read with nesting on sets the nesting status bit of the serviced priority level.
// - A set nesting status bit blocks fast sources of that priority and lower.
// - Each write to the nesting status clears only its lowest-indexed set bit.
// - Four pins and two logic-array lines each select level or edge triggering.
// - Trigger code 11 is falling edge, 10 rising edge, 01 low level and 00 high level.
// - Trigger fields sit at 1:0, 3:2, 5:4, 7:6, 9:8 and 11:10, upper bits reserved.
// - Clear bits sit at 13, 16, 17, 18, 19 and 20 and drop the latched edge.
// - Nesting control bit 1 turns fast nesting and priorities on, off when zero.
// - With nesting off, fast and normal requests still go out, fast ahead of normal.
module fiv_fast_irq_ctrl (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trigger inputs, asynchronous
  input  wire logic [3:0]  ext_pin,
  input  wire logic [1:0]  logic_irq,
  // Rest of the controller, same clock
  input  wire logic [27:0] src_raw,
  input  wire logic [27:0] fast_source_enable,
  input  wire logic [27:0] normal_source_enable,
  input  wire logic [83:0] src_prio,
  input  wire logic [fiv_pkg::VEC_BASE_W-1:0] vector_base,
  // Requests to the core
  output logic             fiq_req,
  output logic             irq_req,
  output logic [4:0]       fiq_src,
  // Event interrupt
  output logic             evt_irq
);
  import fiv_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic             arready;
    logic             rvalid;
    logic             aw_have;
    logic             w_have;
    logic [31:0]      aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic [1:0]       bresp;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [1:0]       nest_ctrl;
    logic [11:0]      trig_sel;
    logic [7:0]       fast_stat;
    logic [2:0]       evt_stat;
    logic [2:0]       evt_mask;
    logic [NTRIG-1:0] edge_clr;
    logic             fiq_req;
    logic             irq_req;
    logic [4:0]       fiq_src;
    logic [2:0]       fiq_lvl;
    logic             evt_irq;
  } fiv_top_state_t;

  localparam fiv_top_state_t RST_STATE = '{
    nest_ctrl: RST_NEST_CTRL,
    trig_sel:  RST_TRIG_SEL,
    fast_stat: RST_FAST_STAT,
    evt_stat:  RST_EVT,
    evt_mask:  RST_EVT,
    default:   '0
  };

  fiv_top_state_t   s_r;
  fiv_top_state_t   s_nxt;

  logic [NTRIG-1:0] trig_in;
  logic [NTRIG-1:0] trig_pend;
  logic [27:0]      pend_all;
  logic             f_any;
  logic [4:0]       f_src;
  logic [2:0]       f_lvl;
  logic             do_wr;
  logic             pop;
  logic             push;
  logic [31:0]      vec_word;
  logic [2:0]       evt_set;

  // Byte-lane merge of a write into a stored register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // ----------------------------------------------------------------
  // Trigger conditioning
  // ----------------------------------------------------------------
  assign trig_in = {logic_irq, ext_pin};

  // One conditioner per pin or logic-array line
  for (genvar k = 0; k < NTRIG; k++) begin : g_cond
    fiv_trig_cond u_cond (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .src_async (trig_in[k]),
      .mode      (s_r.trig_sel[TRIG_LSB[k] +: 2]),
      .edge_clr  (s_r.edge_clr[k]),
      .pending   (trig_pend[k])
    );
  end

  // Six conditioned lines take the place of their raw slots
  always_comb begin
    pend_all = src_raw;
    for (int k = 0; k < NTRIG; k++) begin
      pend_all[SRC_IDX[k]] = trig_pend[k];
    end
  end

  // ----------------------------------------------------------------
  // Fast arbitration
  // ----------------------------------------------------------------
  // Only enabled sources compete; enables come from outside
  fiv_prio_pick u_pick (
    .req     (pend_all & fast_source_enable),
    .prio    (src_prio),
    .nest_en (s_r.nest_ctrl[NEST_FAST_BIT]),
    .stat    (s_r.fast_stat),
    .any     (f_any),
    .src     (f_src),
    .lvl     (f_lvl)
  );

  // Vector word built from the registered winner
  assign vec_word = {9'h000, vector_base, s_r.fiq_src, 2'h0};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.edge_clr = '0;
    pop            = 1'b0;
    push           = 1'b0;

    // Address and data are taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Write takes effect once both halves are held
    do_wr = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    if (do_wr) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      case (s_r.aw_addr)
        OFS_NEST_CTRL: begin
          s_nxt.nest_ctrl = 2'(merge(32'(s_r.nest_ctrl), s_r.w_data, s_r.w_strb));
        end
        OFS_TRIG_SEL: begin
          s_nxt.trig_sel = 12'(merge(32'(s_r.trig_sel), s_r.w_data, s_r.w_strb));
        end
        OFS_EDGE_CLR: begin
          for (int k = 0; k < NTRIG; k++) begin
            s_nxt.edge_clr[k] = s_r.w_data[CLR_BIT[k]] & s_r.w_strb[CLR_BIT[k] / 8];
          end
        end
        OFS_FAST_STAT: begin
          pop = 1'b1;
        end
        OFS_EVT_STAT: begin
          s_nxt.evt_stat = s_r.evt_stat & ~s_r.w_data[2:0];
        end
        OFS_EVT_MASK: begin
          s_nxt.evt_mask = 3'(merge(32'(s_r.evt_mask), s_r.w_data, s_r.w_strb));
        end
        OFS_FAST_VEC: begin
          // Read-only: write is acknowledged and dropped
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read returns one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      s_nxt.rdata  = 32'h00000000;
      case (s_axi_araddr)
        OFS_NEST_CTRL: s_nxt.rdata = 32'(s_r.nest_ctrl);
        OFS_TRIG_SEL:  s_nxt.rdata = 32'(s_r.trig_sel);
        OFS_EDGE_CLR:  s_nxt.rdata = 32'h00000000;
        OFS_FAST_STAT: s_nxt.rdata = 32'(s_r.fast_stat);
        OFS_EVT_STAT:  s_nxt.rdata = 32'(s_r.evt_stat);
        OFS_EVT_MASK:  s_nxt.rdata = 32'(s_r.evt_mask);
        OFS_FAST_VEC: begin
          s_nxt.rdata = vec_word;
          // Reading the vector marks the level as in service
          push = s_r.nest_ctrl[NEST_FAST_BIT] && s_r.fiq_req;
        end
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end

    // Drop the lowest set level, then a new level may set (set wins)
    if (pop && lowest_set8(s_r.fast_stat) < 4'(NLVL)) begin
      s_nxt.fast_stat[3'(lowest_set8(s_r.fast_stat))] = 1'b0;
    end
    if (push) begin
      s_nxt.fast_stat[s_r.fiq_lvl] = 1'b1;
    end
    // Nesting switched off leaves no level in service
    if (!s_nxt.nest_ctrl[NEST_FAST_BIT]) begin
      s_nxt.fast_stat = RST_FAST_STAT;
    end

    // One write and one read in flight at a time
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // Fast request masks the normal one
    s_nxt.fiq_req = f_any;
    s_nxt.irq_req = |(pend_all & normal_source_enable) && !f_any;
    s_nxt.fiq_src = f_src;
    s_nxt.fiq_lvl = f_lvl;

    // Sticky events; a new event wins over a clear write
    evt_set                = '0;
    evt_set[EVT_FAST_BIT]  = s_nxt.fiq_req && !s_r.fiq_req;
    evt_set[EVT_NORM_BIT]  = s_nxt.irq_req && !s_r.irq_req;
    evt_set[EVT_PUSH_BIT]  = push;
    s_nxt.evt_stat         = s_nxt.evt_stat | evt_set;
    s_nxt.evt_irq          = |(s_nxt.evt_stat & s_nxt.evt_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a flop of the state
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign fiq_req       = s_r.fiq_req;
  assign irq_req       = s_r.irq_req;
  assign fiq_src       = s_r.fiq_src;
  assign evt_irq       = s_r.evt_irq;

endmodule

`default_nettype wire

/* tb/fiv_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Bus and request checker
// ----------------------------------------------------------------
module fiv_chk (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Read channels
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Write response
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Requests
  input  wire logic [27:0] fast_source_enable,
  input  wire logic [fiv_pkg::VEC_BASE_W-1:0] vector_base,
  input  wire logic        fiq_req,
  input  wire logic        irq_req,
  input  wire logic [4:0]  fiq_src
);
  import fiv_pkg::*;

  logic [31:0] ar_r;
  logic        mapped;

  // Keep the read address so each answer is judged by its register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ar_r <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_r <= s_axi_araddr;
    end
  end

  // The event registers count as mapped too
  assign mapped = ar_r inside {OFS_NEST_CTRL, OFS_TRIG_SEL, OFS_EDGE_CLR, OFS_FAST_VEC,
                               OFS_FAST_STAT, OFS_EVT_STAT, OFS_EVT_MASK};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_vec_word: assert property (s_axi_rvalid && ar_r == OFS_FAST_VEC |->
    s_axi_rdata[31:23] == 9'h0 && s_axi_rdata[1:0] == 2'h0 &&
    s_axi_rdata[22:7] == vector_base && s_axi_rdata[6:2] <= 5'h1B)
    else $error("vector word badly formed");
  a_fiq_src_range: assert property (fiq_req |-> fiq_src <= 5'h1B)
    else $error("fast source number out of range");
  a_fast_first: assert property (fiq_req |-> !irq_req)
    else $error("normal request beside a fast one");
  a_fiq_enabled: assert property (fiq_req |->
    ((($past(fast_source_enable)) >> fiq_src) & 28'h1) != 28'h0)
    else $error("fast request from a disabled source");
  a_unmapped_err: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_clear_reads0: assert property (s_axi_rvalid && ar_r == OFS_EDGE_CLR |->
    s_axi_rdata == 32'h0)
    else $error("edge clear register reads nonzero");
  a_stat_upper: assert property (s_axi_rvalid && ar_r == OFS_FAST_STAT |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("nesting status upper bits set");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");

  c_vec_read: cover property (s_axi_rvalid && ar_r == OFS_FAST_VEC);
  c_fiq: cover property (fiq_req);
  c_irq: cover property (irq_req);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind fiv_fast_irq_ctrl fiv_chk fiv_chk_inst (
  .sys_clk, .reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .fast_source_enable, .vector_base, .fiq_req, .irq_req, .fiq_src
);

`default_nettype wire

/* tb/fiv_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// External pins and logic-array lines
// ----------------------------------------------------------------
module fiv_pin_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Wanted levels, logic lines 1..0 then pins 3..0
  input  wire logic [5:0] want,
  // Driven lines
  output logic [3:0]      ext_pin,
  output logic [1:0]      logic_irq
);
  // Lines move just after an edge, far from the sync flops; idle low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {logic_irq, ext_pin} <= 6'h0;
    end else begin
      {logic_irq, ext_pin} <= want;
    end
  end
endmodule

`default_nettype wire

/* tb/fiv_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module fast_irq_vector_and_ext_trigger_tb;
  import fiv_pkg::*;

  logic                  sys_clk, reset;
  logic [31:0]           s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0]            s_axi_awprot, s_axi_arprot;
  logic [3:0]            s_axi_wstrb, ext_pin;
  logic [1:0]            s_axi_bresp, s_axi_rresp, logic_irq;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready, fiq_req, irq_req, evt_irq;
  logic [27:0]           src_raw, fast_source_enable, normal_source_enable;
  logic [83:0]           src_prio;
  logic [VEC_BASE_W-1:0] vector_base;
  logic [4:0]            fiq_src;
  logic [5:0]            want;
  int                    failures, tests_run;

  fiv_fast_irq_ctrl fiv_fast_irq_ctrl_inst (
    .sys_clk, .reset, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_pin, .logic_irq, .src_raw, .fast_source_enable, .normal_source_enable,
    .src_prio, .vector_base, .fiq_req, .irq_req, .fiq_src, .evt_irq
  );
  fiv_pin_model fiv_pin_model_inst (.sys_clk, .reset, .want, .ext_pin, .logic_irq);

  // ----------------------------------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Both write halves go out together; each drops once its ready is seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
      end
    end
  endtask

  // Data is only compared when the read is expected to succeed
  task automatic rd(input logic [31:0] a, input logic [31:0] ex,
                    input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
        if (er === RESP_OKAY) chk(s_axi_rdata, ex);
      end
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole run needs some 1400 cycles
  initial begin
    wait_n(20000);
    failures++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {src_raw, fast_source_enable, normal_source_enable} = 84'h0;
    src_prio = 84'h0;
    vector_base = 16'h0000;
    want = 6'h00;
    failures = 0;
    tests_run = 0;
    wait_n(8);
    reset <= 1'b0;
    wait_n(2);
    rd(OFS_TRIG_SEL, 32'h0);
    rd(OFS_FAST_STAT, 32'h0);
    rd(OFS_EDGE_CLR, 32'h0);
    wr(OFS_FAST_VEC, 32'hFFFFFFFF);
    rd(OFS_NEST_CTRL, 32'h0);
    rd(32'hFFFF0100, 32'h0, RESP_SLVERR);
    wr(32'hFFFF0100, 32'h1, RESP_SLVERR);
    wr(OFS_TRIG_SEL, 32'h00000E4B);
    rd(OFS_TRIG_SEL, 32'h00000E4B);
    // Every trigger code on every input, edge latches dropped by their clear bit
    for (int i = 0; i < NTRIG; i++) begin
      fast_source_enable <= 28'h1 << SRC_IDX[i];
      for (int m = 0; m < 4; m++) begin
        wr(OFS_TRIG_SEL, 32'(m) << TRIG_LSB[i]);
        want[i] <= m[0];
        wait_n(8);
        wr(OFS_EDGE_CLR, 32'h1 << CLR_BIT[i]);
        wait_n(8);
        chk(32'(fiq_req), 32'h0);
        want[i] <= ~m[0];
        wait_n(8);
        chk({27'(fiq_req), fiq_src}, {27'h1, 5'(SRC_IDX[i])});
        want[i] <= m[0];
        wait_n(8);
        chk(32'(fiq_req), 32'(m[1]));
        wr(OFS_EDGE_CLR, 32'h1 << CLR_BIT[i]);
        wait_n(8);
        chk(32'(fiq_req), 32'h0);
      end
    end
    want <= 6'h00;
    // Nesting: source 5 at level 3, source 2 at level 0
    vector_base <= 16'hA5C3;
    src_prio <= 84'h3 << 15;
    fast_source_enable <= 28'h0000024;
    src_raw <= 28'h0000020;
    wr(OFS_NEST_CTRL, 32'h2);
    wait_n(8);
    // Vector read with nesting on and a fast request standing sets level 3 in service
    rd(OFS_FAST_VEC, {9'h000, 16'hA5C3, 5'h05, 2'h0});
    rd(OFS_FAST_STAT, 32'h08);
    wait_n(4);
    chk(32'(fiq_req), 32'h0);
    src_raw <= 28'h0000024;
    wait_n(8);
    chk({27'(fiq_req), fiq_src}, {27'h1, 5'h02});
    rd(OFS_FAST_VEC, {9'h000, 16'hA5C3, 5'h02, 2'h0});
    rd(OFS_FAST_STAT, 32'h09);
    wr(OFS_FAST_STAT, 32'hFF);
    rd(OFS_FAST_STAT, 32'h08);
    wr(OFS_FAST_STAT, 32'hFF);
    rd(OFS_FAST_STAT, 32'h00);
    rd(OFS_FAST_VEC, {9'h000, 16'hA5C3, 5'h02, 2'h0});
    rd(OFS_FAST_STAT, 32'h01);
    wr(OFS_NEST_CTRL, 32'h0);
    rd(OFS_FAST_STAT, 32'h00);
    // Nesting off: levels ignored, lowest number wins, no status pushed
    src_prio <= 84'h7 << 6;
    wait_n(8);
    chk({27'(fiq_req), fiq_src}, {27'h1, 5'h02});
    rd(OFS_NEST_CTRL, 32'h0);
    rd(OFS_FAST_STAT, 32'h00);
    src_raw <= 28'h00000A4;
    normal_source_enable <= 28'h0000080;
    wait_n(8);
    chk({30'h0, irq_req, fiq_req}, 32'h1);
    fast_source_enable <= 28'h0;
    wait_n(8);
    chk({30'h0, irq_req, fiq_req}, 32'h2);
    // Event interrupt: raise, mask, clear
    wr(OFS_EVT_STAT, 32'h7);
    rd(OFS_EVT_STAT, 32'h0);
    fast_source_enable <= 28'h0000004;
    wait_n(8);
    rd(OFS_EVT_STAT, 32'h1);
    chk(32'(evt_irq), 32'h0);
    wr(OFS_EVT_MASK, 32'h1);
    wait_n(2);
    chk(32'(evt_irq), 32'h1);
    wr(OFS_EVT_STAT, 32'h1);
    wait_n(2);
    chk(32'(evt_irq), 32'h0);
    rd(OFS_EVT_STAT, 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire
